// File: hdl/stp_pkg.sv
// Package for the shared timer prescaler and event flag block.
// Assumes a single 200 MHz core clock and an AHB-Lite register bus.
package stp_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] STP_OFS_TIMER_EVENT_FLAGS     = 8'h00;
	localparam logic [7:0] STP_OFS_EXT_TIMER_EVENT_FLAGS = 8'h04;
	localparam logic [7:0] STP_OFS_SPECIAL_FUNC_CTRL     = 8'h08;
	localparam logic [7:0] STP_OFS_CLOCK_SELECT          = 8'h0C;
	localparam logic [7:0] STP_OFS_WAVEFORM_MODE         = 8'h10;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int STP_BIT_T1_OVF     = 2;
	localparam int STP_BIT_T3_CAPTURE = 5;
	localparam int STP_BIT_T3_MATCH_A = 4;
	localparam int STP_BIT_T3_MATCH_B = 3;
	localparam int STP_BIT_T3_OVF     = 2;
	localparam int STP_BIT_T3_MATCH_C = 1;
	localparam int STP_BIT_T1_MATCH_C = 0;
	localparam int STP_BIT_SYNC_MODE  = 7;
	localparam int STP_BIT_T0_PSR     = 1;
	localparam int STP_BIT_SHARED_PSR = 0;

	// ---------------------------------------------------------------
	// Reset values and masks
	// ---------------------------------------------------------------
	localparam logic [7:0] STP_RST_FLAGS     = 8'h00;
	localparam logic [7:0] STP_RST_SFC       = 8'h00;
	localparam logic [7:0] STP_EXT_FLAG_MASK = 8'h3F;

	// ---------------------------------------------------------------
	// Prescaler
	// ---------------------------------------------------------------
	localparam int         STP_PRESC_W   = 10;
	localparam logic [9:0] STP_TAP8_MASK = 10'h007;
	localparam logic [9:0] STP_TAP64_MSK = 10'h03F;
	localparam logic [9:0] STP_TAP256_MK = 10'h0FF;
	localparam logic [9:0] STP_TAP1K_MSK = 10'h3FF;

	// Clock select codes
	typedef enum logic [2:0] {
		STP_CS_STOP    = 3'h0,
		STP_CS_DIRECT  = 3'h1,
		STP_CS_DIV8    = 3'h2,
		STP_CS_DIV64   = 3'h3,
		STP_CS_DIV256  = 3'h4,
		STP_CS_DIV1024 = 3'h5,
		STP_CS_EXT_FALL = 3'h6,
		STP_CS_EXT_RISE = 3'h7
	} stp_clk_sel_t;

	// Waveform modes relevant to the flags
	localparam logic [3:0] STP_WGM_NORMAL  = 4'h0;
	localparam logic [3:0] STP_WGM_CTC_OCR = 4'h4;
	localparam logic [3:0] STP_WGM_CTC_ICR = 4'hC;
	localparam logic [3:0] STP_WGM_PWM_ICR_A = 4'h8;
	localparam logic [3:0] STP_WGM_PWM_ICR_B = 4'hA;
	localparam logic [3:0] STP_WGM_PWM_ICR_C = 4'hE;

	// Timer events coming from the counter units
	typedef struct packed {
		logic overflow;
		logic match_a;
		logic match_b;
		logic match_c;
		logic at_top;
		logic capture;
		logic force_a;
		logic force_b;
		logic force_c;
	} stp_tmr_evt_t;

	// Interrupt vector acknowledges
	typedef struct packed {
		logic t1_overflow;
		logic t1_match_c;
		logic t3_capture;
		logic t3_match_a;
		logic t3_match_b;
		logic t3_overflow;
		logic t3_match_c;
	} stp_vec_ack_t;

endpackage : stp_pkg

// File: hdl/stp_shared_prescaler.sv
// Shared prescaler, external count synchronizers and timer event flags.
// Assumes events and acknowledges are one-cycle pulses on i_core_clk,
// and that count pins are synchronous to i_core_clk.
//
// Functional notes
// - Timer 1 overflow flag sets on overflow in normal and clear-on-match modes.
// - Timer 1 overflow flag clears on vector execution or written one.
// - Timer 3 capture flag, bit 5, sets on a capture pin event.
// - With capture value as TOP, capture flag sets when counter reaches TOP.
// - Extended flags clear on vector execution or written one; zero ignored.
// - Match flags set in the timer clock cycle after counter equals compare.
// - A forced compare strobe never sets a match flag.
// - Timer 3 overflow flag, bit 2, sets on overflow in normal and clear-on-match.
// - One prescaler serves timers 1, 2, 3; each has own clock select.
// - Select 1 is the system clock; selects 2 to 5 tap divide by 8/64/256/1024.
// - Prescaler runs freely; clock select never resets it.
// - First prescaled count comes 1 to N+1 cycles after enabling.
// - Prescaler reset restarts the phase for every connected timer.
// - Count inputs sampled each cycle, then fed to an edge detector.
// - Select 7 counts rising edges, select 6 falling edges.
// - External edge reaches counter update after 2.5 to 3.5 cycles.
// - External edge pulses clock the timer directly, bypassing the prescaler.
// - In sync mode both prescaler reset bits keep their written values.
// - Writing sync mode zero clears both prescaler reset bits in hardware.
// - Shared prescaler reset bit clears immediately unless sync mode set.
// - Clock select zero stops the timer.
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module stp_shared_prescaler
	import stp_pkg::*;
#(
	parameter int NUM_TIMERS = 3
) (
	input  wire logic                  i_core_clk,
	input  wire logic                  i_sys_rst,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// External count pins, timers 1..3
	input  wire logic [NUM_TIMERS-1:0] i_ext_count_input,
	// Timer events from the counter units
	input  wire stp_tmr_evt_t          i_t1_evt,
	input  wire stp_tmr_evt_t          i_t3_evt,
	input  wire stp_vec_ack_t          i_vec_ack,
	// Timer clock enables, one pulse per count
	output logic      [NUM_TIMERS-1:0] o_timer_tick,
	output logic                       o_t0_prescaler_reset,
	output logic      [7:0]            o_timer_event_flags,
	output logic      [7:0]            o_ext_timer_event_flags
);

	// ---------------------------------------------------------------
	// Bus slave
	// ---------------------------------------------------------------
	logic       wr_pend_r;
	logic       rd_pend_r;
	logic [7:0] addr_r;
	wire  logic bus_take;

	assign bus_take  = hsel & hready & htrans[1];
	// Zero wait states, every response OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r    <= 8'h00;
		end else begin
			wr_pend_r <= bus_take & hwrite;
			rd_pend_r <= bus_take & ~hwrite;
			// Address kept for the data phase
			if (bus_take)
				addr_r <= haddr[7:0];
		end
	end

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	wire logic hit_flags;
	wire logic hit_ext;
	wire logic hit_sfc;
	wire logic hit_cs;
	wire logic hit_wgm;
	assign hit_flags = (addr_r == STP_OFS_TIMER_EVENT_FLAGS);
	assign hit_ext   = (addr_r == STP_OFS_EXT_TIMER_EVENT_FLAGS);
	assign hit_sfc   = (addr_r == STP_OFS_SPECIAL_FUNC_CTRL);
	assign hit_cs    = (addr_r == STP_OFS_CLOCK_SELECT);
	assign hit_wgm   = (addr_r == STP_OFS_WAVEFORM_MODE);

	wire logic wr_flags;
	wire logic wr_ext;
	wire logic wr_sfc;
	wire logic wr_cs;
	wire logic wr_wgm;
	assign wr_flags = wr_pend_r & hit_flags;
	assign wr_ext   = wr_pend_r & hit_ext;
	assign wr_sfc   = wr_pend_r & hit_sfc;
	assign wr_cs    = wr_pend_r & hit_cs;
	assign wr_wgm   = wr_pend_r & hit_wgm;

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	logic [3*NUM_TIMERS-1:0] clock_select_bits_r;
	logic [7:0]              waveform_mode_bits_r;
	logic                    timer_sync_mode_r;
	logic                    shared_prescaler_reset_r;
	logic                    t0_prescaler_reset_r;
	logic                    shared_psr_nxt;
	logic                    t0_psr_nxt;

	// Sync mode as it will stand after this cycle
	wire logic sync_nxt;
	assign sync_nxt = wr_sfc ? hwdata[STP_BIT_SYNC_MODE] : timer_sync_mode_r;

	always_comb begin
		shared_psr_nxt = shared_prescaler_reset_r;
		t0_psr_nxt     = t0_prescaler_reset_r;
		if (wr_sfc) begin
			shared_psr_nxt = hwdata[STP_BIT_SHARED_PSR];
			t0_psr_nxt     = hwdata[STP_BIT_T0_PSR];
		end
		if (!sync_nxt && !wr_sfc) begin
			shared_psr_nxt = 1'b0;
			t0_psr_nxt     = 1'b0;
		end
		if (wr_sfc && !hwdata[STP_BIT_SYNC_MODE] && timer_sync_mode_r) begin
			shared_psr_nxt = 1'b0;
			t0_psr_nxt     = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			clock_select_bits_r      <= '0;
			waveform_mode_bits_r     <= 8'h00;
			timer_sync_mode_r        <= STP_RST_SFC[STP_BIT_SYNC_MODE];
			shared_prescaler_reset_r <= 1'b0;
			t0_prescaler_reset_r     <= 1'b0;
		end else begin
			if (wr_cs)
				clock_select_bits_r <= hwdata[3*NUM_TIMERS-1:0];
			if (wr_wgm)
				waveform_mode_bits_r <= hwdata[7:0];
			if (wr_sfc)
				timer_sync_mode_r <= hwdata[STP_BIT_SYNC_MODE];
			shared_prescaler_reset_r <= shared_psr_nxt;
			t0_prescaler_reset_r     <= t0_psr_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Prescaler reset outputs
	// ---------------------------------------------------------------
	// A write of one takes effect in its own cycle as well
	// so the divider cannot step during the write
	wire logic psr_active;
	assign psr_active = shared_prescaler_reset_r | (wr_sfc & hwdata[STP_BIT_SHARED_PSR]);
	assign o_t0_prescaler_reset = t0_prescaler_reset_r | (wr_sfc & hwdata[STP_BIT_T0_PSR]);

	// ---------------------------------------------------------------
	// Shared prescaler
	// ---------------------------------------------------------------
	logic [STP_PRESC_W-1:0] presc_r;

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			presc_r <= '0;
		else if (psr_active)
			presc_r <= '0;
		else
			presc_r <= presc_r + 10'h001;
	end

	// ---------------------------------------------------------------
	// Prescaler taps
	// ---------------------------------------------------------------
	// taps at 8, 64, 256, 1024
	// free phase gives 1 to N+1
	// Masked during reset so no tick escapes
	wire logic tap8;
	wire logic tap64;
	wire logic tap256;
	wire logic tap1024;
	assign tap8    = ((presc_r & STP_TAP8_MASK) == STP_TAP8_MASK) & ~psr_active;
	assign tap64   = ((presc_r & STP_TAP64_MSK) == STP_TAP64_MSK) & ~psr_active;
	assign tap256  = ((presc_r & STP_TAP256_MK) == STP_TAP256_MK) & ~psr_active;
	assign tap1024 = ((presc_r & STP_TAP1K_MSK) == STP_TAP1K_MSK) & ~psr_active;

	// ---------------------------------------------------------------
	// Per timer sync, edge detect and clock select
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
			logic         sample_r;
			logic         prev_r;
			logic         tick_r;
			stp_clk_sel_t sel;
			logic         tick_nxt;

			assign sel = stp_clk_sel_t'(clock_select_bits_r[3*g +: 3]);

			// three cycles pin to counter
			// Pin is already synchronous: one sample stage,
			// a second would push the delay past 3.5 cycles
			always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					sample_r <= 1'b0;
					prev_r   <= 1'b0;
					tick_r   <= 1'b0;
				end else begin
					sample_r <= i_ext_count_input[g];
					prev_r   <= sample_r;
					tick_r   <= tick_nxt;
				end
			end

			always_comb begin
				unique case (sel)
					STP_CS_STOP:     tick_nxt = 1'b0;
					STP_CS_DIRECT:   tick_nxt = 1'b1;
					STP_CS_DIV8:     tick_nxt = tap8;
					STP_CS_DIV64:    tick_nxt = tap64;
					STP_CS_DIV256:   tick_nxt = tap256;
					STP_CS_DIV1024:  tick_nxt = tap1024;
					STP_CS_EXT_FALL: tick_nxt = prev_r & ~sample_r;
					STP_CS_EXT_RISE: tick_nxt = ~prev_r & sample_r;
				endcase
			end

			assign o_timer_tick[g] = tick_r;
		end
	endgenerate

	// ---------------------------------------------------------------
	// Event flags
	// ---------------------------------------------------------------
	logic [7:0] t1_flags_r;
	logic [7:0] ext_flags_r;
	logic [7:0] t1_set;
	logic [7:0] t1_clr;
	logic [7:0] ext_set;
	logic [7:0] ext_clr;
	wire  logic t1_ovf_mode;
	wire  logic t3_ovf_mode;
	wire  logic t3_icr_top;
	wire  logic [3:0] t1_wgm;
	wire  logic [3:0] t3_wgm;

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	assign t1_wgm = waveform_mode_bits_r[3:0];
	assign t3_wgm = waveform_mode_bits_r[7:4];
	// Overflow flags only in normal and clear-on-match modes
	assign t1_ovf_mode = (t1_wgm == STP_WGM_NORMAL) | (t1_wgm == STP_WGM_CTC_OCR) | (t1_wgm == STP_WGM_CTC_ICR);
	assign t3_ovf_mode = (t3_wgm == STP_WGM_NORMAL) | (t3_wgm == STP_WGM_CTC_OCR) | (t3_wgm == STP_WGM_CTC_ICR);
	assign t3_icr_top  = (t3_wgm == STP_WGM_CTC_ICR) | (t3_wgm == STP_WGM_PWM_ICR_A)
	                   | (t3_wgm == STP_WGM_PWM_ICR_B) | (t3_wgm == STP_WGM_PWM_ICR_C);

	// ---------------------------------------------------------------
	// Flag sources
	// ---------------------------------------------------------------
	always_comb begin
		t1_set = 8'h00;
		t1_clr = 8'h00;
		ext_set = 8'h00;
		ext_clr = 8'h00;
		t1_set[STP_BIT_T1_OVF] = i_t1_evt.overflow & t1_ovf_mode;
		t1_clr[STP_BIT_T1_OVF] = i_vec_ack.t1_overflow | (wr_flags & hwdata[STP_BIT_T1_OVF]);
		// counter at TOP when capture value is TOP
		ext_set[STP_BIT_T3_CAPTURE] = i_t3_evt.capture | (i_t3_evt.at_top & t3_icr_top);
		// match events arrive on the following timer tick
		ext_set[STP_BIT_T3_MATCH_A] = i_t3_evt.match_a & ~i_t3_evt.force_a;
		ext_set[STP_BIT_T3_MATCH_B] = i_t3_evt.match_b & ~i_t3_evt.force_b;
		ext_set[STP_BIT_T3_MATCH_C] = i_t3_evt.match_c & ~i_t3_evt.force_c;
		ext_set[STP_BIT_T1_MATCH_C] = i_t1_evt.match_c & ~i_t1_evt.force_c;
		ext_set[STP_BIT_T3_OVF] = i_t3_evt.overflow & t3_ovf_mode;
		ext_clr = (wr_ext ? (hwdata[7:0] & STP_EXT_FLAG_MASK) : 8'h00);
		ext_clr[STP_BIT_T3_CAPTURE] = ext_clr[STP_BIT_T3_CAPTURE] | i_vec_ack.t3_capture;
		ext_clr[STP_BIT_T3_MATCH_A] = ext_clr[STP_BIT_T3_MATCH_A] | i_vec_ack.t3_match_a;
		ext_clr[STP_BIT_T3_MATCH_B] = ext_clr[STP_BIT_T3_MATCH_B] | i_vec_ack.t3_match_b;
		ext_clr[STP_BIT_T3_OVF]     = ext_clr[STP_BIT_T3_OVF] | i_vec_ack.t3_overflow;
		ext_clr[STP_BIT_T3_MATCH_C] = ext_clr[STP_BIT_T3_MATCH_C] | i_vec_ack.t3_match_c;
		ext_clr[STP_BIT_T1_MATCH_C] = ext_clr[STP_BIT_T1_MATCH_C] | i_vec_ack.t1_match_c;
	end

	// ---------------------------------------------------------------
	// Flag cells
	// ---------------------------------------------------------------
	// Set wins over a clear in the same cycle, so an event
	// landing on a software clear is never lost
	// Unused positions are tied low and read as zero
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_flag
			wire logic t1_used;
			wire logic ext_used;
			assign t1_used  = (b == STP_BIT_T1_OVF);
			assign ext_used = STP_EXT_FLAG_MASK[b];
			always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					t1_flags_r[b]  <= STP_RST_FLAGS[b];
					ext_flags_r[b] <= STP_RST_FLAGS[b];
				end else begin
					t1_flags_r[b]  <= t1_used & (t1_set[b] | (t1_flags_r[b] & ~t1_clr[b]));
					ext_flags_r[b] <= ext_used & (ext_set[b] | (ext_flags_r[b] & ~ext_clr[b]));
				end
			end
		end
	endgenerate

	assign o_timer_event_flags     = t1_flags_r;
	assign o_ext_timer_event_flags = ext_flags_r;

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	// Read data stands only in the data phase
	wire logic [7:0] sfc_rd;
	assign sfc_rd = {timer_sync_mode_r, 5'h00, t0_prescaler_reset_r, shared_prescaler_reset_r};

	always_comb begin
		hrdata = 32'h0000_0000;
		if (rd_pend_r) begin
			unique case (addr_r)
				STP_OFS_TIMER_EVENT_FLAGS:     hrdata = {24'h000000, t1_flags_r};
				STP_OFS_EXT_TIMER_EVENT_FLAGS: hrdata = {24'h000000, ext_flags_r};
				STP_OFS_SPECIAL_FUNC_CTRL:     hrdata = {24'h000000, sfc_rd};
				STP_OFS_CLOCK_SELECT:          hrdata = {{(32-3*NUM_TIMERS){1'b0}}, clock_select_bits_r};
				STP_OFS_WAVEFORM_MODE:         hrdata = {24'h000000, waveform_mode_bits_r};
				default:                       hrdata = 32'h0000_0000;
			endcase
		end
	end

endmodule : stp_shared_prescaler
`default_nettype wire

// File: tb/stp_asserts.sv
// Checker for the shared prescaler and flag block.
// Sees only top ports; bound in at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module stp_asserts
	import stp_pkg::*;
#(
	parameter int NUM_TIMERS = 3
) (
	input wire logic         i_core_clk,
	input wire logic         i_sys_rst,
	input wire logic         hsel,
	input wire logic [31:0]  haddr,
	input wire logic [1:0]   htrans,
	input wire logic         hwrite,
	input wire logic [31:0]  hwdata,
	input wire logic         hready,
	input wire logic         hreadyout,
	input wire logic         hresp,
	input wire stp_tmr_evt_t i_t1_evt,
	input wire stp_tmr_evt_t i_t3_evt,
	input wire stp_vec_ack_t i_vec_ack,
	input wire logic [7:0]   o_timer_event_flags,
	input wire logic [7:0]   o_ext_timer_event_flags
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);

	wire ext_addr = hsel & hready & htrans[1] & hwrite & (haddr[7:0] == STP_OFS_EXT_TIMER_EVENT_FLAGS);

	// ----------------------------------------
	// Sequences and properties
	// ----------------------------------------
	sequence s_ext_write;
		ext_addr ##1 1'b1;
	endsequence
	property p_t1_ovf_clr;
		i_vec_ack.t1_overflow && !i_t1_evt.overflow |=> !o_timer_event_flags[STP_BIT_T1_OVF];
	endproperty
	property p_cap_set;
		i_t3_evt.capture |=> o_ext_timer_event_flags[STP_BIT_T3_CAPTURE];
	endproperty
	property p_match_set;
		i_t3_evt.match_a && !i_t3_evt.force_a |=> o_ext_timer_event_flags[STP_BIT_T3_MATCH_A];
	endproperty
	property p_force_none;
		i_t3_evt.force_a && !o_ext_timer_event_flags[STP_BIT_T3_MATCH_A] |=> !o_ext_timer_event_flags[4];
	endproperty
	property p_ext_ack;
		i_vec_ack.t3_match_c && !i_t3_evt.match_c |=> !o_ext_timer_event_flags[STP_BIT_T3_MATCH_C];
	endproperty
	property p_ext_w1c;
		s_ext_write ##0 (hwdata[3] && !i_t3_evt.match_b) |=> !o_ext_timer_event_flags[3];
	endproperty
	property p_ext_hold;
		o_ext_timer_event_flags[1] && !i_vec_ack.t3_match_c && !($past(ext_addr) && hwdata[1])
			|=> o_ext_timer_event_flags[1];
	endproperty
	property p_rsvd;
		o_ext_timer_event_flags[7:6] == 2'h0 && o_timer_event_flags[7:3] == 5'h00 && o_timer_event_flags[1:0] == 2'h0;
	endproperty
	property p_bus_ok;
		hreadyout && !hresp;
	endproperty

	a_t1_ovf_clr: assert property (p_t1_ovf_clr) else $error("t1 overflow flag not cleared");
	a_cap_set: assert property (p_cap_set) else $error("capture flag not set");
	a_match_set: assert property (p_match_set) else $error("match a flag not set");
	a_force_none: assert property (p_force_none) else $error("forced strobe set a flag");
	a_ext_ack: assert property (p_ext_ack) else $error("match c flag not cleared by ack");
	a_ext_w1c: assert property (p_ext_w1c) else $error("match b flag not cleared by write");
	a_ext_hold: assert property (p_ext_hold) else $error("match c flag lost");
	a_rsvd: assert property (p_rsvd) else $error("unused flag bit set");
	a_bus_ok: assert property (p_bus_ok) else $error("bus response not ready okay");
endmodule : stp_asserts

bind stp_shared_prescaler stp_asserts #(.NUM_TIMERS(NUM_TIMERS)) u_chk (
	.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.i_t1_evt(i_t1_evt), .i_t3_evt(i_t3_evt), .i_vec_ack(i_vec_ack),
	.o_timer_event_flags(o_timer_event_flags), .o_ext_timer_event_flags(o_ext_timer_event_flags));
`default_nettype wire

// File: tb/stp_pin_model.sv
// External count source model.
// Gives a burst of whole periods, low at rest.
`timescale 1ns/100ps
`default_nettype none
module stp_pin_model #(
	parameter int HALF = 3
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_start,
	input  wire logic [7:0] i_periods,
	output logic            o_pin
);
	logic [8:0] halves_r;
	logic [7:0] div_r;
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			halves_r <= 9'h000;
			div_r <= 8'h00;
			o_pin <= 1'b0;
		end else if (i_start) begin
			halves_r <= {i_periods, 1'b0};
			div_r <= 8'h00;
		end else if (halves_r != 9'h000) begin
			if (div_r == 8'(HALF - 1)) begin
				div_r <= 8'h00;
				o_pin <= ~o_pin;
				halves_r <= halves_r - 9'h001;
			end else begin
				div_r <= div_r + 8'h01;
			end
		end
	end
endmodule : stp_pin_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the shared prescaler block.
// Drives AHB-Lite, timer events and one count pin model.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import stp_pkg::*;
	logic         i_core_clk = 1'b0;
	logic         i_sys_rst = 1'b1;
	logic         hsel = 1'b0;
	logic         hwrite = 1'b0;
	logic         start = 1'b0;
	logic [31:0]  haddr = 32'h0;
	logic [31:0]  hwdata = 32'h0;
	logic [1:0]   htrans = 2'h0;
	logic [7:0]   periods = 8'h00;
	stp_tmr_evt_t t1e = '0;
	stp_tmr_evt_t t3e = '0;
	stp_vec_ack_t ack = '0;
	wire          pin;
	wire [31:0]   hrdata;
	wire          hreadyout;
	wire          t0r;
	wire [2:0]    tick;
	int           miscompares = 0;
	int           total_checks = 0;
	int           c[3];
	int           coin;

	stp_shared_prescaler i_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .i_ext_count_input({3{pin}}), .i_t1_evt(t1e), .i_t3_evt(t3e),
		.i_vec_ack(ack), .o_timer_tick(tick), .o_t0_prescaler_reset(t0r), .o_timer_event_flags(),
		.o_ext_timer_event_flags());
	stp_pin_model #(.HALF(3)) i_pin (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_start(start),
		.i_periods(periods), .o_pin(pin));

	initial forever #2.5 i_core_clk = ~i_core_clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		for (int p = 0; p < 2; p++) begin
			n = 0;
			do begin
				@(posedge i_core_clk);
				n++;
			end while (hreadyout !== 1'b1 && n < 50);
			if (n >= 50) begin
				miscompares++;
				finish_test();
			end
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
		end
		q = hrdata;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), q, e);
	endtask : rdc

	task evt(input logic [8:0] a, input logic [8:0] b, input logic [6:0] k);
		t1e <= stp_tmr_evt_t'(a);
		t3e <= stp_tmr_evt_t'(b);
		ack <= stp_vec_ack_t'(k);
		@(posedge i_core_clk);
		t1e <= '0;
		t3e <= '0;
		ack <= '0;
		@(posedge i_core_clk);
	endtask : evt

	task run(input int cyc);
		repeat (4) @(posedge i_core_clk);
		c = '{0, 0, 0};
		coin = 0;
		repeat (cyc) begin
			@(posedge i_core_clk);
			for (int i = 0; i < 3; i++) c[i] += int'(tick[i] === 1'b1);
			coin += int'(tick[0] !== tick[1]);
		end
	endtask : run

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_flags;
		rdc(8'h20, 32'h0);
		rdc(8'h04, 32'h0);
		wr(8'h10, 32'h0);
		evt(9'h100, 9'h000, 7'h00);
		rdc(8'h00, 32'h4);
		wr(8'h00, 32'h4);
		rdc(8'h00, 32'h0);
		evt(9'h100, 9'h000, 7'h00);
		evt(9'h000, 9'h000, 7'h40);
		rdc(8'h00, 32'h0);
		wr(8'h10, 32'h1);
		evt(9'h100, 9'h000, 7'h00);
		rdc(8'h00, 32'h0);
		wr(8'h10, 32'h0);
		evt(9'h020, 9'h1E8, 7'h00);
		rdc(8'h04, 32'h3F);
		wr(8'h04, 32'h0);
		rdc(8'h04, 32'h3F);
		wr(8'h04, 32'h3F);
		rdc(8'h04, 32'h0);
		evt(9'h021, 9'h084, 7'h00);
		rdc(8'h04, 32'h0);
		wr(8'h10, 32'hC0);
		evt(9'h000, 9'h030, 7'h00);
		rdc(8'h04, 32'h22);
		evt(9'h000, 9'h000, 7'h11);
		rdc(8'h04, 32'h0);
		$display("t_flags done");
	endtask : t_flags

	task t_presc;
		int n;
		wr(8'h0C, 32'h5A);
		run(64);
		chk("div8 ticks", 32'(c[0]), 32'h8);
		chk("div64 ticks", 32'(c[1]), 32'h1);
		chk("direct ticks", 32'(c[2]), 32'h40);
		wr(8'h0C, 32'h0);
		run(64);
		chk("stopped ticks", 32'(c[0] + c[1] + c[2]), 32'h0);
		wr(8'h0C, 32'h12);
		n = 0;
		while (tick[0] !== 1'b1 && n < 20) begin
			@(posedge i_core_clk);
			n++;
		end
		chk("first count", 32'(n >= 2 && n <= 10), 32'h1);
		wr(8'h08, 32'h1);
		rdc(8'h08, 32'h0);
		wr(8'h08, 32'h83);
		rdc(8'h08, 32'h83);
		run(40);
		chk("held ticks", 32'(c[0] + c[1]), 32'h0);
		chk("t0 reset held", 32'(t0r), 32'h1);
		wr(8'h08, 32'h0);
		n = 0;
		while (tick[1] !== 1'b1 && n < 20) begin
			@(posedge i_core_clk);
			n++;
		end
		chk("restart phase", 32'(n), 32'h9);
		rdc(8'h08, 32'h0);
		run(64);
		chk("released ticks", 32'(c[0]), 32'h8);
		chk("phase split", 32'(coin), 32'h0);
		$display("t_presc done");
	endtask : t_presc

	task t_ext;
		int n;
		int a;
		wr(8'h0C, 32'h187);
		periods <= 8'h05;
		start <= 1'b1;
		@(posedge i_core_clk);
		start <= 1'b0;
		run(40);
		chk("rise ticks", 32'(c[0]), 32'h5);
		chk("fall ticks", 32'(c[2]), 32'h5);
		chk("unselected ticks", 32'(c[1]), 32'h0);
		periods <= 8'h01;
		start <= 1'b1;
		@(posedge i_core_clk);
		start <= 1'b0;
		n = 0;
		while (pin !== 1'b1 && n < 20) begin
			@(posedge i_core_clk);
			n++;
		end
		a = n;
		while (tick[0] !== 1'b1 && n < 40) begin
			@(posedge i_core_clk);
			n++;
		end
		chk("edge latency", 32'(n - a + 1), 32'h3);
		$display("t_ext done");
	endtask : t_ext

	initial begin
		repeat (12) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_core_clk);
		t_flags();
		t_presc();
		t_ext();
		finish_test();
	end

	initial begin
		#300000;
		miscompares++;
		finish_test();
	end
endmodule : testbench
`default_nettype wire
